// [core/sptc_core.sv]
`timescale 1ns/100ps
// How it works
// - Calibration filter code picks corner, 4-7 same.
// - Coil self-test timing ignores calibration filter code.
// - Narrow calibration band slows compensation settling.
// - Magnetic filter code picks corner, 4-7 same.
// - Upper clamp field inverted: zero means maximum.
// - Lower clamp field plain: zero means minimum.
// - Rate field picks PWM frequency or tick.
// - Signed quiescent trim shifts output from factory.
// - Coarse gain doubles per code, 5-7 32x.
// - Signed fine gain applies after coarse gain.
module sptc_core
    import sptc_pkg::*;
#(
    parameter logic [11:0] FACTORY_QUIESCENT_LEVEL = 12'h800
) (
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic               sample_valid,
    input  wire logic signed [15:0] sample_in,
    input  wire logic               coil_self_test,
    output logic                    out_valid,
    output logic      [11:0]        out_level,
    output sptc_cfg_t               cfg_out,
    output logic      [10:0]        cal_corner,
    output logic      [12:0]        sig_corner,
    output logic                    self_test_out
);

    // Decodes the calibration path corner from its select code.
    function automatic logic [10:0] cal_hz_f(input logic [2:0] code);
        case (code)
            3'h0:    cal_hz_f = CAL_C0;
            3'h1:    cal_hz_f = CAL_C1;
            3'h2:    cal_hz_f = CAL_C2;
            3'h3:    cal_hz_f = CAL_C3;
            default: cal_hz_f = CAL_C4;
        endcase
    endfunction : cal_hz_f

    // Decodes the magnetic path corner from its select code.
    function automatic logic [12:0] sig_hz_f(input logic [2:0] code);
        case (code)
            3'h0:    sig_hz_f = SIG_C0;
            3'h1:    sig_hz_f = SIG_C1;
            3'h2:    sig_hz_f = SIG_C2;
            3'h3:    sig_hz_f = SIG_C3;
            default: sig_hz_f = SIG_C4;
        endcase
    endfunction : sig_hz_f

    // Turns a bus byte address into a register index match.
    function automatic logic hit_f(input logic [7:0] addr, input logic [7:0] idx);
        hit_f = (addr == {idx[5:0], 2'b00});
    endfunction : hit_f

    sptc_cfg_t          cfg_q;        // Trim set as software left it.
    logic               wait_q;       // Registered waitrequest.
    logic [31:0]        rdata_q;      // Registered read data.
    logic [10:0]        cal_hz_q;     // Calibration corner, 0.01 Hz units.
    logic [12:0]        sig_hz_q;     // Magnetic corner in Hz.
    logic               st_q;         // Self-test flag to the analog side.
    logic [2:0]         shift_q;      // Saturated coarse shift.
    logic               s1_valid_q;   // Stage one holds a product.
    logic signed [33:0] s1_prod_q;    // Gained sample before offset.
    logic               s2_valid_q;   // Stage two holds an output.
    logic [11:0]        s2_level_q;   // Clamped output code.
    logic               wr_ok;        // A write completes this edge.
    logic               rd_start;     // A read is first seen this edge.
    logic [11:0]        hi_lim;       // Upper clamp as an output code.
    logic [11:0]        lo_lim;       // Lower clamp as an output code.
    logic signed [21:0] coarse_v;     // Sample after the coarse shift.
    logic signed [11:0] fine_mul;     // Fine multiplier, unity 1024.
    logic signed [25:0] sum_v;        // Level before clamping.

    // The request completes on the edge where waitrequest is seen low.
    assign wr_ok    = avs_write && !wait_q;
    assign rd_start = avs_read && wait_q;

    // Waitrequest drops for one cycle after each request is seen, so every
    // access takes exactly two edges; a fixed answer keeps the slave simple.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((avs_read || avs_write) && wait_q);
        end
    end

    // Register writes; unmapped addresses are ignored.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q.cal_path_filter_select <= CALF_RST;
            cfg_q.signal_filter_select   <= SIGF_RST;
            cfg_q.coarse_gain            <= COARSE_RST;
            cfg_q.fine_gain              <= FINE_RST;
            cfg_q.quiescent_offset_trim  <= QSH_RST;
            cfg_q.upper_limit_level      <= UPPER_RST;
            cfg_q.lower_limit_level      <= LOWER_RST;
            cfg_q.output_tick_select     <= RATE_RST;
        end else if (wr_ok) begin
            if (hit_f(avs_address, IDX_PATH)) begin
                cfg_q.fine_gain              <= avs_writedata[FINE_LSB +: 11];
                cfg_q.coarse_gain            <= avs_writedata[COARSE_LSB +: 3];
                cfg_q.signal_filter_select   <= avs_writedata[SIGF_LSB +: 3];
                cfg_q.cal_path_filter_select <= avs_writedata[CALF_LSB +: 3];
            end else if (hit_f(avs_address, IDX_QSHIFT)) begin
                cfg_q.quiescent_offset_trim  <= avs_writedata[QSH_LSB +: 16];
            end else if (hit_f(avs_address, IDX_CLAMP)) begin
                cfg_q.upper_limit_level      <= avs_writedata[UPPER_LSB +: 12];
                cfg_q.lower_limit_level      <= avs_writedata[LOWER_LSB +: 12];
            end else if (hit_f(avs_address, IDX_RATE)) begin
                // The same field serves PWM or SENT; the encoder reads it.
                cfg_q.output_tick_select     <= avs_writedata[RATE_LSB +: 5];
            end
        end
    end

    // Read data is captured on the first edge and held for the second.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_start) begin
            rdata_q <= 32'h0000_0000;
            if (hit_f(avs_address, IDX_PATH)) begin
                rdata_q[FINE_LSB +: 11]  <= cfg_q.fine_gain;
                rdata_q[COARSE_LSB +: 3] <= cfg_q.coarse_gain;
                rdata_q[SIGF_LSB +: 3]   <= cfg_q.signal_filter_select;
                rdata_q[CALF_LSB +: 3]   <= cfg_q.cal_path_filter_select;
            end else if (hit_f(avs_address, IDX_QSHIFT)) begin
                rdata_q[QSH_LSB +: 16]   <= cfg_q.quiescent_offset_trim;
            end else if (hit_f(avs_address, IDX_CLAMP)) begin
                rdata_q[UPPER_LSB +: 12] <= cfg_q.upper_limit_level;
                rdata_q[LOWER_LSB +: 12] <= cfg_q.lower_limit_level;
            end else if (hit_f(avs_address, IDX_RATE)) begin
                rdata_q[RATE_LSB +: 5]   <= cfg_q.output_tick_select;
            end else if (hit_f(avs_address, IDX_STATUS)) begin
                // Decoded corners show what the filters really run at.
                rdata_q[10:0]  <= cal_hz_q;
                rdata_q[28:16] <= sig_hz_q;
            end else if (hit_f(avs_address, IDX_OUTPUT)) begin
                rdata_q[11:0]  <= s2_level_q;
                rdata_q[16]    <= s2_valid_q;
            end
        end
    end

    // Corner decode for the two noise filters. Codes above four saturate.
    // A narrow calibration corner trades noise for slower compensation
    // settling; nothing here hides that, software must pick with care.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cal_hz_q <= CAL_C0;
            sig_hz_q <= SIG_C0;
        end else begin
            cal_hz_q <= cal_hz_f(cfg_q.cal_path_filter_select);
            sig_hz_q <= sig_hz_f(cfg_q.signal_filter_select);
        end
    end

    // The self-test request bypasses the calibration filter entirely, so its
    // timing is the same under every filter code.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= 1'b0;
        end else begin
            st_q <= coil_self_test;
        end
    end

    // Coarse shift saturates at five, that is 32 times.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            shift_q <= 3'h0;
        end else if (cfg_q.coarse_gain > COARSE_MAX) begin
            shift_q <= COARSE_MAX;
        end else begin
            shift_q <= cfg_q.coarse_gain;
        end
    end

    // Coarse gain first, then the signed fine multiplier around unity.
    assign coarse_v = 22'(sample_in) <<< shift_q;
    assign fine_mul = 12'sd1024 + 12'(signed'(cfg_q.fine_gain));

    // Stage one: gain the sample.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_valid_q <= 1'b0;
            s1_prod_q  <= '0;
        end else begin
            s1_valid_q <= sample_valid;
            if (sample_valid) begin
                // Both factors are widened first so that the product cannot wrap.
                s1_prod_q <= 34'(coarse_v) * 34'(fine_mul);
            end
        end
    end

    // Clamp limits as output codes; the upper field counts down.
    assign hi_lim = OUT_FULL - cfg_q.upper_limit_level;
    assign lo_lim = cfg_q.lower_limit_level;

    // Offset from the factory level plus the signed trim.
    assign sum_v = 26'(s1_prod_q >>> FINE_FRAC)
                 + 26'(signed'({1'b0, FACTORY_QUIESCENT_LEVEL}))
                 + 26'(signed'(cfg_q.quiescent_offset_trim));

    // Stage two: clamp. The lower limit is tested first, so if software sets the limits
    // crossed over, a level at or above it still takes the upper limit.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s2_valid_q <= 1'b0;
            s2_level_q <= 12'h000;
        end else begin
            s2_valid_q <= s1_valid_q;
            if (s1_valid_q) begin
                if (sum_v < 26'(signed'({1'b0, lo_lim}))) begin
                    s2_level_q <= lo_lim;
                end else if (sum_v > 26'(signed'({1'b0, hi_lim}))) begin
                    s2_level_q <= hi_lim;
                end else begin
                    s2_level_q <= sum_v[11:0];
                end
            end
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign out_valid       = s2_valid_q;
    assign out_level       = s2_level_q;
    assign cfg_out         = cfg_q;
    assign cal_corner      = cal_hz_q;
    assign sig_corner      = sig_hz_q;
    assign self_test_out   = st_q;

    // A sample appears two edges after it is offered.
    sequence seq_in;
        sample_valid;
    endsequence
    sequence seq_out;
        ##2 out_valid;
    endsequence
    // A bus request answers on the following cycle.
    sequence seq_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    // Decoded values lag the trim set by one edge, so most checks use |=>.
    // The clamp checks assume that software leaves the limits alone while samples flow.
    AST_CAL_SAT: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfg_q.cal_path_filter_select >= FILT_MAX |=> cal_corner == CAL_C4)
        else $error("calibration corner not saturated");
    AST_CAL_LOW: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfg_q.cal_path_filter_select == 3'h0 |=> cal_corner == CAL_C0)
        else $error("calibration corner wrong for code zero");
    AST_SIG_SAT: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfg_q.signal_filter_select >= FILT_MAX |=> sig_corner == SIG_C4)
        else $error("magnetic corner not saturated");
    AST_SIG_LOW: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfg_q.signal_filter_select == 3'h0 |=> sig_corner == SIG_C0)
        else $error("magnetic corner wrong for code zero");
    AST_SELF_TEST: assert property (@(posedge sys_clk) disable iff (!rstn)
        coil_self_test |=> self_test_out)
        else $error("self-test delayed");
    AST_UPPER: assert property (@(posedge sys_clk) disable iff (!rstn)
        out_valid && lo_lim <= hi_lim |-> out_level <= hi_lim)
        else $error("output above upper clamp");
    AST_LOWER: assert property (@(posedge sys_clk) disable iff (!rstn)
        out_valid |-> out_level >= lo_lim)
        else $error("output below lower clamp");
    AST_RATE: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_ok && hit_f(avs_address, IDX_RATE)
        |=> cfg_out.output_tick_select == $past(avs_writedata[7:3]))
        else $error("rate field not stored");
    AST_QUIESCENT: assert property (@(posedge sys_clk) disable iff (!rstn)
        sample_valid && sample_in == 16'sh0000 && $stable(cfg_q)
        && lo_lim <= FACTORY_QUIESCENT_LEVEL && hi_lim >= FACTORY_QUIESCENT_LEVEL
        && cfg_q.quiescent_offset_trim == 16'h0000
        |-> ##2 out_level == FACTORY_QUIESCENT_LEVEL)
        else $error("zero sample not at factory level");
    AST_COARSE: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfg_q.coarse_gain > COARSE_MAX |=> shift_q == COARSE_MAX)
        else $error("coarse gain not saturated");
    AST_COARSE_PASS: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfg_q.coarse_gain <= COARSE_MAX |=> shift_q == $past(cfg_q.coarse_gain))
        else $error("coarse gain code not applied");
    AST_PIPE: assert property (@(posedge sys_clk) disable iff (!rstn)
        seq_in |-> seq_out)
        else $error("gain pipeline latency wrong");
    AST_BUS: assert property (@(posedge sys_clk) disable iff (!rstn)
        seq_req |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");

endmodule : sptc_core

// [core/sptc_pkg.sv]
package sptc_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_PATH   = 8'h03;
    localparam logic [7:0] IDX_QSHIFT = 8'h06;
    localparam logic [7:0] IDX_CLAMP  = 8'h08;
    localparam logic [7:0] IDX_RATE   = 8'h14;
    localparam logic [7:0] IDX_STATUS = 8'h20;
    localparam logic [7:0] IDX_OUTPUT = 8'h21;
    // Field positions (low bit of each field).
    localparam int FINE_LSB   = 0;
    localparam int COARSE_LSB = 12;
    localparam int SIGF_LSB   = 16;
    localparam int CALF_LSB   = 19;
    localparam int UPPER_LSB  = 0;
    localparam int LOWER_LSB  = 12;
    localparam int RATE_LSB   = 3;
    localparam int QSH_LSB    = 0;
    // Reset values of the trim fields.
    localparam logic [2:0]  CALF_RST   = 3'h0;
    localparam logic [2:0]  SIGF_RST   = 3'h0;
    localparam logic [2:0]  COARSE_RST = 3'h0;
    localparam logic [10:0] FINE_RST   = 11'h000;
    localparam logic [15:0] QSH_RST    = 16'h0000;
    localparam logic [11:0] UPPER_RST  = 12'h000;
    localparam logic [11:0] LOWER_RST  = 12'h000;
    localparam logic [4:0]  RATE_RST   = 5'h00;
    // Full scale of the 12-bit output code.
    localparam logic [11:0] OUT_FULL   = 12'hfff;
    // Highest coarse shift; codes above it saturate.
    localparam logic [2:0]  COARSE_MAX = 3'h5;
    // Highest filter code with its own corner; codes above share it.
    localparam logic [2:0]  FILT_MAX   = 3'h4;
    // Unity of the fine gain multiplier (fraction bits).
    localparam int          FINE_FRAC  = 10;
    // Calibration path corners in units of 0.01 Hz.
    localparam logic [10:0] CAL_C0 = 11'h008;
    localparam logic [10:0] CAL_C1 = 11'h01e;
    localparam logic [10:0] CAL_C2 = 11'h07d;
    localparam logic [10:0] CAL_C3 = 11'h190;
    localparam logic [10:0] CAL_C4 = 11'h640;
    // Magnetic path corners in Hz.
    localparam logic [12:0] SIG_C0 = 13'h0028;
    localparam logic [12:0] SIG_C1 = 13'h00a0;
    localparam logic [12:0] SIG_C2 = 13'h02a8;
    localparam logic [12:0] SIG_C3 = 13'h0bb8;
    localparam logic [12:0] SIG_C4 = 13'h1ce8;

    // Software visible trim set, carried as one word.
    typedef struct packed {
        logic [2:0]  cal_path_filter_select;
        logic [2:0]  signal_filter_select;
        logic [2:0]  coarse_gain;
        logic [10:0] fine_gain;
        logic [15:0] quiescent_offset_trim;
        logic [11:0] upper_limit_level;
        logic [11:0] lower_limit_level;
        logic [4:0]  output_tick_select;
    } sptc_cfg_t;
endpackage : sptc_pkg

// [test/sptc_ctrl_model.sv]
`timescale 1ns/100ps
// Controller on the output line: it takes every code the block presents.
module sptc_ctrl_model
    import sptc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        out_valid,
    input  wire logic [11:0] out_level,
    output logic      [15:0] rx_count,
    output logic      [11:0] rx_last
);
    // Capture each presented code once, on its single valid cycle.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_count <= 16'h0000;
            rx_last  <= 12'h000;
        end else if (out_valid) begin
            rx_count <= rx_count + 16'h0001;
            rx_last  <= out_level;
        end
    end
endmodule : sptc_ctrl_model

// [test/sptc_core_tb_top.sv]
`timescale 1ns/100ps
// Register and sample path tests for the trim bank.
module sptc_core_tb_top
    import sptc_pkg::*;
;
    logic               sys_clk, rstn, avs_read, avs_write, avs_waitrequest;
    logic        [7:0]  avs_address;
    logic        [31:0] avs_writedata, avs_readdata, rd;
    logic               sample_valid, coil_self_test, out_valid, self_test_out;
    logic signed [15:0] sample_in;
    logic        [11:0] out_level, rx_last;
    logic        [10:0] cal_corner;
    logic        [12:0] sig_corner;
    logic        [15:0] rx_count, sent;
    sptc_cfg_t          cfg_out;
    int                 mismatches, comparisons;
    // Expected corners per code; codes above four share the last one.
    logic [10:0] cal_tab [8] = '{11'h008, 11'h01e, 11'h07d, 11'h190,
                                 11'h640, 11'h640, 11'h640, 11'h640};
    logic [12:0] sig_tab [8] = '{13'h0028, 13'h00a0, 13'h02a8, 13'h0bb8,
                                 13'h1ce8, 13'h1ce8, 13'h1ce8, 13'h1ce8};
    // Clamp scenario samples and the codes they must produce.
    logic [15:0] qv [4] = '{16'h0400, 16'hfc00, 16'h7fff, 16'h8001};
    logic [11:0] qe [4] = '{12'hfff, 12'h000, 12'heff, 12'h300};

    sptc_core i_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sample_valid(sample_valid), .sample_in(sample_in),
        .coil_self_test(coil_self_test), .out_valid(out_valid), .out_level(out_level),
        .cfg_out(cfg_out), .cal_corner(cal_corner), .sig_corner(sig_corner),
        .self_test_out(self_test_out));
    sptc_ctrl_model i_ctrl (.sys_clk(sys_clk), .rstn(rstn), .out_valid(out_valid),
        .out_level(out_level), .rx_count(rx_count), .rx_last(rx_last));

    // Free running clock, 4 ns period.
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Single compare for all values; case equality keeps unknowns visible.
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // One bus access; the request stands until waitrequest is sampled low.
    // Only the watchdog ends a hung wait; one idle edge separates accesses.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        cmp("bus cycles", 32'd2, 32'(n));
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    // Read a register and compare it.
    task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp("readdata", exp, rd);
    endtask : rd_cmp

    // Send one sample; out_valid must show exactly two edges after it is taken.
    task automatic smp(input logic [15:0] s, input logic [11:0] exp);
        sample_valid <= 1'b1;
        sample_in    <= s;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        @(posedge sys_clk);
        cmp("early valid", 32'h0, {31'h0, out_valid});
        @(posedge sys_clk);
        cmp("out_valid", 32'h1, {31'h0, out_valid});
        cmp("out_level", {20'h0, exp}, {20'h0, out_level});
        sent++;
    endtask : smp

    // Verdict and end of run.
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    // Watchdog: the tests take a few hundred cycles.
    initial begin
        #80000;
        mismatches++;
        results();
    end

    // Main test sequence.
    initial begin
        int c;
        rstn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
        avs_writedata = 32'h0; sample_valid = 1'b0; sample_in = 16'sh0000;
        coil_self_test = 1'b0; mismatches = 0; comparisons = 0; sent = 16'h0;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd_cmp(8'h0c, 32'h0); rd_cmp(8'h18, 32'h0); rd_cmp(8'h50, 32'h0);
        rd_cmp(8'h20, 32'h0);
        cmp("cal_corner", 32'h8, {21'h0, cal_corner});
        // Every filter code, with the self-test delay unchanged by it.
        for (c = 0; c < 8; c++) begin
            bus(1'b1, 8'h0c, (c << 19) | (c << 16));
            rd_cmp(8'h0c, (c << 19) | (c << 16));
            rd_cmp(8'h80, {3'h0, sig_tab[c], 5'h0, cal_tab[c]});
            cmp("sig_corner", {19'h0, sig_tab[c]}, {19'h0, sig_corner});
            coil_self_test <= 1'b1;
            @(posedge sys_clk);
            coil_self_test <= 1'b0;
            @(posedge sys_clk);
            cmp("self_test_out", 32'h1, {31'h0, self_test_out});
        end
        // Coarse gain: doubling per code, saturating at code five.
        for (c = 0; c < 8; c++) begin
            bus(1'b1, 8'h0c, c << 12);
            smp(16'h0003, 12'h800 + (12'h3 << ((c > 5) ? 5 : c)));
        end
        bus(1'b1, 8'h0c, 32'h0000_0200);
        smp(16'd100, 12'h896);
        bus(1'b1, 8'h0c, 32'h0000_0600);
        smp(16'd100, 12'h832);
        bus(1'b1, 8'h0c, 32'h0000_1200);
        smp(16'd100, 12'h92c);
        bus(1'b1, 8'h0c, 32'h0000_2000);
        // Signed quiescent shift around the factory level.
        bus(1'b1, 8'h18, 32'h0000_fff0);
        rd_cmp(8'h18, 32'h0000_fff0);
        smp(16'h0000, 12'h7f0);
        bus(1'b1, 8'h18, 32'h0000_0010);
        smp(16'h0000, 12'h810);
        bus(1'b1, 8'h18, 32'h0);
        // Clamps at defaults (coarse 4x), then moved inward.
        smp(qv[0], qe[0]);
        smp(qv[1], qe[1]);
        bus(1'b1, 8'h0c, 32'h0);
        bus(1'b1, 8'h20, 32'hff30_0100);
        rd_cmp(8'h20, 32'h0030_0100);
        smp(qv[2], qe[2]);
        smp(qv[3], qe[3]);
        smp(16'h0000, 12'h800);
        // Rate field only, other bits read zero.
        bus(1'b1, 8'h50, 32'hffff_ffff);
        rd_cmp(8'h50, 32'h0000_00f8);
        cmp("tick", 32'h1f, {27'h0, cfg_out.output_tick_select});
        // Unmapped place: write ignored, read zero, neighbours untouched.
        bus(1'b1, 8'h40, 32'hffff_ffff);
        rd_cmp(8'h40, 32'h0);
        rd_cmp(8'h50, 32'h0000_00f8);
        rd_cmp(8'h84, 32'h0000_0800);
        cmp("rx_count", {16'h0, sent}, {16'h0, rx_count});
        cmp("rx_last", 32'h800, {20'h0, rx_last});
        results();
    end
endmodule : sptc_core_tb_top
